// file: rtl/eif_cfg.svh
`ifndef EIF_CFG_SVH
`define EIF_CFG_SVH

// ----------------------------------------------------------------------
// Alias offsets within the flag register group
// ----------------------------------------------------------------------
`define EIF_OFS_FLAGS      4'h0
`define EIF_OFS_CLR        4'h4
`define EIF_OFS_SET        4'h8
`define EIF_OFS_INV        4'hC

// ----------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------
`define EIF_BIT_TXBUSERR   14
`define EIF_BIT_RXBUSERR   13
`define EIF_BIT_EMPTYWM    9
`define EIF_BIT_FULLWM     8
`define EIF_BIT_RX_PACKET_DONE_FLAG     7

// ----------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------
`define EIF_STICKY_MASK    32'h0000_6080
`define EIF_FLAGS_RESET    32'h0000_0000
`define EIF_CNT_W          8
`define EIF_CNT_RESET      8'h00
`define EIF_CNT_MAX        8'hFF

`endif

// file: rtl/eif_pkg.sv
package eif_pkg;

   // Alias selected by the word offset of an access
   typedef enum logic [1:0]
   {
      ALIAS_DIRECT = 2'b00,
      ALIAS_CLR    = 2'b01,
      ALIAS_SET    = 2'b10,
      ALIAS_INV    = 2'b11
   } eif_alias_type;

endpackage

// file: rtl/eif_wmark_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "eif_cfg.svh"

interface eif_wmark_if;
   logic [`EIF_CNT_W-1:0] count;       // Descriptor buffer count
   logic                  inc;         // Hardware increment
   logic                  dec;         // Software decrement
   logic [`EIF_CNT_W-1:0] emptyThr;    // Empty threshold field
   logic [`EIF_CNT_W-1:0] fullThr;     // Full threshold field
   logic                  emptyFlag;   // Empty watermark flag
   logic                  fullFlag;    // Full watermark flag

   modport flags
   (
      input  count,
      input  emptyFlag,
      input  fullFlag,
      output inc,
      output dec,
      output emptyThr,
      output fullThr
   );

   modport wmark
   (
      output count,
      output emptyFlag,
      output fullFlag,
      input  inc,
      input  dec,
      input  emptyThr,
      input  fullThr
   );
endinterface

`default_nettype wire

// file: rtl/eif_watermark.sv
`timescale 1ns/1ps
`default_nettype none
`include "eif_cfg.svh"

module eif_watermark
(
   input  wire logic  clk,     // System clock
   input  wire logic  rst,     // Async reset, active high
   input  wire logic  ce,      // Clock enable
   eif_wmark_if.wmark wm       // Counter and watermark signals
);

   logic [`EIF_CNT_W-1:0] countReg;
   logic [`EIF_CNT_W-1:0] countNext;
   logic                  emptyReg;
   logic                  emptyNext;
   logic                  fullReg;
   logic                  fullNext;
   logic                  doInc;
   logic                  doDec;

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   // Saturating; simultaneous up and down cancel
   assign doInc     = wm.inc && !wm.dec && (countReg != `EIF_CNT_MAX);
   assign doDec     = wm.dec && !wm.inc && (countReg != `EIF_CNT_RESET);
   assign countNext = doInc ? countReg + 8'h01 :
                      doDec ? countReg - 8'h01 : countReg;

   // ----------------------------------------------------------------------
   // Watermark flags
   // ----------------------------------------------------------------------
   // Condition is re-checked each cycle, so a clear that leaves the
   // count past its threshold reasserts one cycle later
   assign emptyNext = wm.inc ? 1'b0 :
                      (countReg <= wm.emptyThr) ? 1'b1 : emptyReg;
   assign fullNext  = wm.dec ? 1'b0 :
                      (countReg >= wm.fullThr) ? 1'b1 : fullReg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         countReg <= `EIF_CNT_RESET;
         emptyReg <= 1'b0;
         fullReg  <= 1'b0;
      end
      else if (ce)
      begin
         countReg <= countNext;
         emptyReg <= emptyNext;
         fullReg  <= fullNext;
      end
   end

   assign wm.count     = countReg;
   assign wm.emptyFlag = emptyReg;
   assign wm.fullFlag  = fullReg;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_empty_set: assert property (@(posedge clk) disable iff (rst)
      (ce && !wm.inc && countReg <= wm.emptyThr) |=> emptyReg)
      else $error("empty watermark not set at threshold");

   a_empty_clear: assert property (@(posedge clk) disable iff (rst)
      (ce && wm.inc) |=> !emptyReg)
      else $error("empty watermark not cleared by increment");

   a_full_set: assert property (@(posedge clk) disable iff (rst)
      (ce && !wm.dec && countReg >= wm.fullThr) |=> fullReg)
      else $error("full watermark not set at threshold");

   a_full_clear: assert property (@(posedge clk) disable iff (rst)
      (ce && wm.dec) |=> !fullReg)
      else $error("full watermark not cleared by decrement");

   a_count_step: assert property (@(posedge clk) disable iff (rst)
      (ce && wm.inc && !wm.dec && countReg != `EIF_CNT_MAX)
      |=> countReg == $past(countReg) + 8'h01)
      else $error("buffer count did not increment");

endmodule

`default_nettype wire

// file: rtl/eif_irq_flags.sv
// How it works
// - Transmit DMA bus error sets bit 14; reset, the clear or invert alias, or a direct write of zero clears it.
// - Receive DMA bus error sets bit 13; reset, the clear or invert alias, or a direct write of zero clears it.
// - Empty watermark bit 9 sets while count is at or below empty threshold.
// - Hardware increment of the buffer count clears the empty watermark.
// - Full watermark bit 8 sets while count is at or above full threshold.
// - Software decrement strobe clears full watermark and decrements the count.
// - Software writes never change the two watermark bits.
// - Successful packet reception sets bit 7; reset, the clear or invert alias, or a direct write of zero clears it.
// - Offsets 0x4, 0x8, 0xC clear, set or toggle the bits written as one.
`timescale 1ns/1ps
`default_nettype none
`include "eif_cfg.svh"

module eif_irq_flags
(
   input  wire logic        clk,                // System clock, 250 MHz
   input  wire logic        rst,                // Async reset, active high
   input  wire logic        ce,                 // Clock enable, freezes state
   input  wire logic        regWrite,           // Register write strobe
   input  wire logic        regRead,            // Register read strobe
   input  wire logic [3:0]  regAddr,            // Byte offset in the group
   input  wire logic [31:0] regWdata,           // Write data
   output logic      [31:0] regRdata,           // Read data, registered
   input  wire logic [31:0] irqEnable,          // Per-flag interrupt enable
   input  wire logic        txBusError,         // Transmit DMA bus error
   input  wire logic        rxBusError,         // Receive DMA bus error
   input  wire logic        rxPacketDone,       // Packet received ok
   input  wire logic        bufCountIncrement,  // Hardware count increment
   input  wire logic        bufCountDecrement,  // Software decrement strobe
   input  wire logic [7:0]  emptyThreshold,     // Empty threshold field
   input  wire logic [7:0]  fullThreshold,      // Full threshold field
   output logic      [7:0]  bufferCount,        // Descriptor buffer count
   output logic             ethernet_interrupt_request_flags              // Interrupt request
);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic logic [31:0] bitOf(input int pos);
      logic [31:0] m;
      m = 32'h0000_0000;
      m[pos] = 1'b1;
      return m;
   endfunction

   function automatic eif_pkg::eif_alias_type aliasOf(input logic [3:0] ofs);
      return eif_pkg::eif_alias_type'(ofs[3:2]);
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   eif_wmark_if wmBus ();

   eif_pkg::eif_alias_type writeAlias;
   logic [31:0] stickyReg;
   logic [31:0] stickyNext;
   logic [31:0] hwSet;
   logic [31:0] swSet;
   logic [31:0] swClr;
   logic [31:0] wdataSticky;
   logic [31:0] readValue;
   logic [31:0] rdataReg;
   logic [31:0] rdataNext;
   logic        isDirect;
   logic        isClr;
   logic        isSet;
   logic        isInv;

   // ----------------------------------------------------------------------
   // Watermark counter
   // ----------------------------------------------------------------------
   assign wmBus.inc      = bufCountIncrement;
   assign wmBus.dec      = bufCountDecrement;
   assign wmBus.emptyThr = emptyThreshold;
   assign wmBus.fullThr  = fullThreshold;

   eif_watermark eif_watermark_inst
   (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .wm  (wmBus.wmark)
   );

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   // Low two address bits ignored; all four words are mapped
   assign writeAlias  = aliasOf(regAddr);
   assign isDirect    = regWrite && (writeAlias == eif_pkg::ALIAS_DIRECT);
   assign isClr       = regWrite && (writeAlias == eif_pkg::ALIAS_CLR);
   assign isSet       = regWrite && (writeAlias == eif_pkg::ALIAS_SET);
   assign isInv       = regWrite && (writeAlias == eif_pkg::ALIAS_INV);

   // Only sticky bits are reachable; watermark bits drop out here
   assign wdataSticky = regWdata & `EIF_STICKY_MASK;

   // Direct write kept as a debug path, same priority as the aliases
   assign swSet = ({32{isDirect}} & wdataSticky)
                | ({32{isSet}}    & wdataSticky)
                | ({32{isInv}}    & wdataSticky & ~stickyReg);
   assign swClr = ({32{isDirect}} & ~wdataSticky & `EIF_STICKY_MASK)
                | ({32{isClr}}    & wdataSticky)
                | ({32{isInv}}    & wdataSticky & stickyReg);

   // ----------------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------------
   assign hwSet = ({32{txBusError}}   & bitOf(`EIF_BIT_TXBUSERR))
                | ({32{rxBusError}}   & bitOf(`EIF_BIT_RXBUSERR))
                | ({32{rxPacketDone}} & bitOf(`EIF_BIT_RX_PACKET_DONE_FLAG));

   // Hardware set wins over a clear in the same cycle, so no event is lost
   assign stickyNext = ((stickyReg & ~swClr) | swSet | hwSet) & `EIF_STICKY_MASK;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         stickyReg <= `EIF_FLAGS_RESET;
      else if (ce)
         stickyReg <= stickyNext;
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Aliases read back the flag word too; unimplemented bits read zero
   assign readValue = stickyReg
                    | ({32{wmBus.emptyFlag}} & bitOf(`EIF_BIT_EMPTYWM))
                    | ({32{wmBus.fullFlag}}  & bitOf(`EIF_BIT_FULLWM));
   assign rdataNext = regRead ? readValue : rdataReg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdataReg <= `EIF_FLAGS_RESET;
      else if (ce)
         rdataReg <= rdataNext;
   end

   assign regRdata    = rdataReg;
   assign bufferCount = wmBus.count;

   // ----------------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------------
   assign ethernet_interrupt_request_flags = |(readValue & irqEnable);

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_txbus_set: assert property (@(posedge clk) disable iff (rst)
      (ce && txBusError) |=> stickyReg[`EIF_BIT_TXBUSERR])
      else $error("tx bus error flag not set");

   a_rxbus_set: assert property (@(posedge clk) disable iff (rst)
      (ce && rxBusError) |=> stickyReg[`EIF_BIT_RXBUSERR])
      else $error("rx bus error flag not set");

   a_rx_packet_done_flag_set: assert property (@(posedge clk) disable iff (rst)
      (ce && rxPacketDone) |=> stickyReg[`EIF_BIT_RX_PACKET_DONE_FLAG])
      else $error("rx done flag not set");

   a_txbus_hold: assert property (@(posedge clk) disable iff (rst)
      (stickyReg[`EIF_BIT_TXBUSERR] && !(ce && swClr[`EIF_BIT_TXBUSERR]))
      |=> stickyReg[`EIF_BIT_TXBUSERR])
      else $error("tx bus error flag lost without clear");

   a_clr_alias: assert property (@(posedge clk) disable iff (rst)
      (ce && regWrite && regAddr == `EIF_OFS_CLR && regWdata[`EIF_BIT_RX_PACKET_DONE_FLAG]
       && !rxPacketDone) |=> !stickyReg[`EIF_BIT_RX_PACKET_DONE_FLAG])
      else $error("clear alias did not clear rx done");

   a_inv_alias: assert property (@(posedge clk) disable iff (rst)
      (ce && regWrite && regAddr == `EIF_OFS_INV && regWdata[`EIF_BIT_RXBUSERR]
       && !rxBusError)
      |=> stickyReg[`EIF_BIT_RXBUSERR] != $past(stickyReg[`EIF_BIT_RXBUSERR]))
      else $error("invert alias did not toggle rx bus error");

   a_wm_unwritable: assert property (@(posedge clk) disable iff (rst)
      (ce && regWrite && regAddr == `EIF_OFS_SET && !bufCountDecrement
       && fullThreshold > wmBus.count && !wmBus.fullFlag)
      |=> !wmBus.fullFlag)
      else $error("software write changed full watermark");

   a_irq_enabled: assert property (@(posedge clk) disable iff (rst)
      (stickyReg[`EIF_BIT_RX_PACKET_DONE_FLAG] && irqEnable[`EIF_BIT_RX_PACKET_DONE_FLAG]) |-> ethernet_interrupt_request_flags)
      else $error("enabled flag did not raise interrupt");

   a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
      (irqEnable == 32'h0000_0000) |-> !ethernet_interrupt_request_flags)
      else $error("interrupt raised with all enables low");

   a_read_data: assert property (@(posedge clk) disable iff (rst)
      (ce && regRead) |=> regRdata == $past(readValue))
      else $error("read data does not match flag word");

   a_rxbus_hold: assert property (@(posedge clk) disable iff (rst)
      (stickyReg[`EIF_BIT_RXBUSERR] && !(ce && swClr[`EIF_BIT_RXBUSERR]))
      |=> stickyReg[`EIF_BIT_RXBUSERR])
      else $error("rx bus error flag lost without clear");

   a_rx_packet_done_flag_hold: assert property (@(posedge clk) disable iff (rst)
      (stickyReg[`EIF_BIT_RX_PACKET_DONE_FLAG] && !(ce && swClr[`EIF_BIT_RX_PACKET_DONE_FLAG]))
      |=> stickyReg[`EIF_BIT_RX_PACKET_DONE_FLAG])
      else $error("rx done flag lost without clear");

   // A clear landing with a new event must not swallow the event
   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      (ce && rxPacketDone && regWrite && regAddr == `EIF_OFS_CLR)
      |=> stickyReg[`EIF_BIT_RX_PACKET_DONE_FLAG])
      else $error("clear beat a same-cycle packet done");

   a_empty_irq: assert property (@(posedge clk) disable iff (rst)
      (wmBus.emptyFlag && irqEnable[`EIF_BIT_EMPTYWM]) |-> ethernet_interrupt_request_flags)
      else $error("enabled empty watermark did not raise interrupt");

endmodule

`default_nettype wire

// file: verif/eif_dma_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Transmit and receive DMA stand-in
// ----------------------------------------------------------------------
module eif_dma_model
(
   input  wire logic clk,           // System clock
   output logic      txBusError,    // Transmit DMA bus error
   output logic      rxBusError,    // Receive DMA bus error
   output logic      rxPacketDone,  // Packet received ok
   output logic      bufCountInc    // Descriptor count increment
);
   initial
   begin
      {txBusError, rxBusError, rxPacketDone, bufCountInc} = 4'h0;
   end

   // One-cycle event: 0 tx error, 1 rx error, 2 packet done, 3 increment
   task automatic pulse(input int unsigned kind);
      @(posedge clk);
      #1;
      txBusError   = (kind == 0);
      rxBusError   = (kind == 1);
      rxPacketDone = (kind == 2);
      bufCountInc  = (kind == 3);
      @(posedge clk);
      #1;
      {txBusError, rxBusError, rxPacketDone, bufCountInc} = 4'h0;
   endtask
endmodule

`default_nettype wire

// file: verif/ethernet_irq_flag_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "eif_cfg.svh"

module ethernet_irq_flag_logic_bench;
   logic        clk, rst, ce, regWrite, regRead, bufCountDecrement, ethernet_interrupt_request_flags;
   logic        txBusError, rxBusError, rxPacketDone, bufCountIncrement;
   logic [3:0]  regAddr;
   logic [31:0] regWdata, regRdata, irqEnable;
   logic [7:0]  emptyThreshold, fullThreshold, bufferCount;
   int          errTotal, nChecks, cycleCount;

   eif_irq_flags eif_irq_flags_inst
   (
      .clk(clk), .rst(rst), .ce(ce), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .irqEnable(irqEnable), .txBusError(txBusError), .rxBusError(rxBusError),
      .rxPacketDone(rxPacketDone), .bufCountIncrement(bufCountIncrement),
      .bufCountDecrement(bufCountDecrement), .emptyThreshold(emptyThreshold),
      .fullThreshold(fullThreshold), .bufferCount(bufferCount), .ethernet_interrupt_request_flags(ethernet_interrupt_request_flags)
   );

   eif_dma_model eif_dma_model_inst
   (
      .clk(clk), .txBusError(txBusError), .rxBusError(rxBusError),
      .rxPacketDone(rxPacketDone), .bufCountInc(bufCountIncrement)
   );

   // ----------------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------------
   always #2 clk = ~clk;

   always @(posedge clk)
   begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 3000)
      begin
         errTotal = errTotal + 1;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      nChecks = nChecks + 1;
      if (seen !== expv)
      begin
         errTotal = errTotal + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic wr_word(input logic [3:0] addr, input logic [31:0] data);
      @(posedge clk);
      #1;
      regWrite = 1'b1;
      regAddr  = addr;
      regWdata = data;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
   endtask

   task automatic rd_word(input logic [3:0] addr, input logic [31:0] expv);
      @(posedge clk);
      #1;
      regRead = 1'b1;
      regAddr = addr;
      @(posedge clk);
      #1;
      regRead = 1'b0;
      check(regRdata, expv);
   endtask

   // Enable is combinational into the request, so settle then look
   task automatic irq_check(input logic [31:0] en, input logic expv);
      irqEnable = en;
      #1;
      check({31'h0000_0000, ethernet_interrupt_request_flags}, {31'h0000_0000, expv});
   endtask

   task automatic dec_count();
      @(posedge clk);
      #1;
      bufCountDecrement = 1'b1;
      @(posedge clk);
      #1;
      bufCountDecrement = 1'b0;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_reset();
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0200);
      check({24'h00_0000, bufferCount}, 32'h0000_0000);
      irq_check(32'h0000_0000, 1'b0);
      $display("test reset done");
   endtask

   task automatic test_events();
      for (int k = 0; k < 3; k++)
         eif_dma_model_inst.pulse(k);
      rd_word(`EIF_OFS_SET, 32'h0000_6280);
      irq_check(32'h0000_4000, 1'b1);
      wr_word(`EIF_OFS_CLR, 32'h0000_4000);
      rd_word(`EIF_OFS_CLR, 32'h0000_2280);
      irq_check(32'h0000_4000, 1'b0);
      wr_word(`EIF_OFS_INV, 32'h0000_2000);
      rd_word(`EIF_OFS_INV, 32'h0000_0280);
      wr_word(`EIF_OFS_SET, 32'h0000_2000);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_2280);
      // Frozen clock enable must swallow the event
      ce = 1'b0;
      eif_dma_model_inst.pulse(0);
      ce = 1'b1;
      rd_word(`EIF_OFS_FLAGS, 32'h0000_2280);
      wr_word(`EIF_OFS_SET, 32'hFFFF_FFFF);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_6280);
      wr_word(`EIF_OFS_CLR, 32'hFFFF_FFFF);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0200);
      // Packet done and a clear in one cycle: the set must win
      fork
         eif_dma_model_inst.pulse(2);
         wr_word(`EIF_OFS_CLR, 32'h0000_0080);
      join
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0280);
      eif_dma_model_inst.pulse(2);
      wr_word(`EIF_OFS_FLAGS, 32'h0000_0000);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0200);
      $display("test events done");
   endtask

   task automatic test_watermarks();
      irq_check(32'h0000_0200, 1'b1);
      eif_dma_model_inst.pulse(3);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0000);
      eif_dma_model_inst.pulse(3);
      eif_dma_model_inst.pulse(3);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0100);
      check({24'h00_0000, bufferCount}, 32'h0000_0003);
      wr_word(`EIF_OFS_SET, 32'h0000_0300);
      wr_word(`EIF_OFS_CLR, 32'h0000_0300);
      wr_word(`EIF_OFS_INV, 32'h0000_0300);
      wr_word(`EIF_OFS_FLAGS, 32'h0000_0000);
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0100);
      dec_count();
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0000);
      check({24'h00_0000, bufferCount}, 32'h0000_0002);
      dec_count();
      dec_count();
      rd_word(`EIF_OFS_FLAGS, 32'h0000_0200);
      $display("test watermarks done");
   endtask

   // Reset in mid-run must drop sticky flags and the count
   task automatic test_midreset();
      wr_word(`EIF_OFS_SET, 32'h0000_6080);
      eif_dma_model_inst.pulse(3);
      @(posedge clk);
      #1;
      rst = 1'b1;
      @(posedge clk);
      #1;
      check(regRdata, 32'h0000_0000);
      check({24'h00_0000, bufferCount}, 32'h0000_0000);
      rst = 1'b0;
      rd_word(4'hF, 32'h0000_0200);
      // Increment and decrement together leave the count alone
      fork
         eif_dma_model_inst.pulse(3);
         dec_count();
      join
      check({24'h00_0000, bufferCount}, 32'h0000_0000);
      dec_count();
      check({24'h00_0000, bufferCount}, 32'h0000_0000);
      $display("test midreset done");
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      {regWrite, regRead, bufCountDecrement} = 3'h0;
      regAddr = 4'h0;
      regWdata = 32'h0000_0000;
      irqEnable = 32'h0000_0000;
      emptyThreshold = 8'h00;
      fullThreshold = 8'h03;
      errTotal = 0;
      nChecks = 0;
      cycleCount = 0;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      test_reset();
      test_events();
      test_watermarks();
      test_midreset();
      report_and_stop();
   end
endmodule

`default_nettype wire
